// ===== logic/ddc_dac_load_ctrl.sv
// Purpose: Serial frame receiver and register control of a dual 16-bit DAC
// Assumes: All pins except arst_n and clk_en are asynchronous to core_clk and pass two flip-flops
// Notes:   Each serial clock half period must span three core clocks
`timescale 1ns/1ns
`default_nettype none
module ddc_dac_load_ctrl #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic serial_clk,
    input wire logic frame_strobe_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    input wire logic clear_n,
    input wire logic load_strobe_n,
    input wire logic port_pin_0_in,
    output logic port_pin_0_out,
    output logic port_pin_0_oe,
    input wire logic port_pin_1_in,
    output logic port_pin_1_out,
    output logic port_pin_1_oe,
    input wire logic output_clamp_in,
    input wire logic coding_select,
    output logic monitor_reset_out,
    output logic output_clamped,
    output logic [15:0] dac_a_code,
    output logic [15:0] dac_b_code
);
    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [ddc_pkg::PIN_N-1:0] pins_raw, s1_q, s2_q, prev_q;
    logic sclk_fall, sclk_rise, frame_fall, frame_rise, clear_fall, load_fall;

    assign pins_raw = {coding_select, output_clamp_in, port_pin_1_in, port_pin_0_in,
        load_strobe_n, clear_n, serial_in, frame_strobe_n, serial_clk};

    // Two-stage synchroniser plus one history stage for edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= ddc_pkg::SYNC_RST;
            s2_q <= ddc_pkg::SYNC_RST;
            prev_q <= ddc_pkg::SYNC_RST;
        end else if (clk_en) begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end

    // Edges seen on synchronised levels only
    assign sclk_fall = prev_q[ddc_pkg::PIN_SCLK] & ~s2_q[ddc_pkg::PIN_SCLK];
    assign sclk_rise = ~prev_q[ddc_pkg::PIN_SCLK] & s2_q[ddc_pkg::PIN_SCLK];
    assign frame_fall = prev_q[ddc_pkg::PIN_FRM] & ~s2_q[ddc_pkg::PIN_FRM];
    assign frame_rise = ~prev_q[ddc_pkg::PIN_FRM] & s2_q[ddc_pkg::PIN_FRM];
    assign clear_fall = prev_q[ddc_pkg::PIN_CLEAR] & ~s2_q[ddc_pkg::PIN_CLEAR];
    assign load_fall = prev_q[ddc_pkg::PIN_LOAD] & ~s2_q[ddc_pkg::PIN_LOAD];

    // ****************************************************************
    // Frame receiver
    // ****************************************************************
    ddc_word_if #(.WIDTH(ddc_pkg::FRAME_BITS)) in_if ();
    ddc_word_if #(.WIDTH(ddc_pkg::FRAME_BITS)) out_if ();

    ddc_pkg::ddc_frame_st_t st_q, st_d;
    logic [ddc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [ddc_pkg::FRAME_BITS-1:0] sh_q, sh_d;
    logic so_q, so_d, so_en_q, so_en_d;
    logic rb_load_q, rb_load_d, rb_pend_q, rb_pend_d;
    logic [15:0] rb_word_q, rb_word_d, func_q, func_d;

    assign in_if.valid = (st_q == ddc_pkg::FR_PUSH);
    assign in_if.data = sh_q;

    // Next receiver state, shift register and serial output
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        so_d = so_q;
        so_en_d = func_q[ddc_pkg::FN_DAISY] | rb_pend_q;
        unique case (st_q)
            ddc_pkg::FR_IDLE: begin
                if (frame_fall) begin
                    st_d = ddc_pkg::FR_SHIFT;
                    cnt_d = '0;
                    so_d = sh_q[ddc_pkg::FRAME_BITS-1];
                end
            end
            ddc_pkg::FR_SHIFT: begin
                if (frame_rise) begin
                    st_d = (cnt_q == ddc_pkg::FRAME_CNT) ? ddc_pkg::FR_PUSH : ddc_pkg::FR_IDLE;
                end else if (sclk_fall) begin
                    sh_d = {sh_q[ddc_pkg::FRAME_BITS-2:0], s2_q[ddc_pkg::PIN_SDI]};
                    cnt_d = (cnt_q == ddc_pkg::FRAME_CNT) ? cnt_q : cnt_q + 1'b1;
                end else if (sclk_rise) begin
                    so_d = sh_q[ddc_pkg::FRAME_BITS-1];
                end
            end
            ddc_pkg::FR_PUSH: begin
                if (in_if.ready) begin
                    st_d = ddc_pkg::FR_IDLE; // Stalls here while buffer is full
                end
            end
            default: begin
                st_d = ddc_pkg::FR_IDLE;
            end
        endcase
        if (rb_load_q) begin
            sh_d = {ddc_pkg::RB_PAD, rb_word_q};
        end
    end

    // Receiver registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ddc_pkg::FR_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            so_q <= 1'b0;
            so_en_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            so_q <= so_d;
            so_en_q <= so_en_d;
        end
    end

    ddc_word_buf #(.WIDTH(ddc_pkg::FRAME_BITS), .DEPTH(BUF_DEPTH)) u_buf (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .wr(in_if),
        .rd(out_if)
    );

    // ****************************************************************
    // Command executor and DAC registers
    // ****************************************************************
    logic take, load_low;
    logic [ddc_pkg::FRAME_BITS-1:0] w;
    logic [3:0] sel;
    logic [2:0] adr;
    logic [15:0] in_a_q, in_a_d, in_b_q, in_b_d, dac_a_q, dac_a_d, dac_b_q, dac_b_d;

    assign out_if.ready = ~clear_fall; // Clear owns the registers in its cycle
    assign take = out_if.valid & out_if.ready;
    assign w = out_if.data;
    assign sel = w[ddc_pkg::SEL_HI:ddc_pkg::SEL_LO];
    assign adr = w[ddc_pkg::ADR_HI:ddc_pkg::ADR_LO];
    assign load_low = ~s2_q[ddc_pkg::PIN_LOAD];

    // Next register values: write, readback, load strobe, clear
    always_comb begin
        in_a_d = in_a_q;
        in_b_d = in_b_q;
        dac_a_d = dac_a_q;
        dac_b_d = dac_b_q;
        func_d = func_q;
        rb_word_d = rb_word_q;
        rb_load_d = 1'b0;
        rb_pend_d = frame_rise ? 1'b0 : rb_pend_q;
        if (take && w[ddc_pkg::RD_BIT]) begin
            rb_load_d = 1'b1;
            rb_pend_d = 1'b1;
            if (sel == ddc_pkg::SEL_FUNC) begin
                rb_word_d = {func_q[15:8], s2_q[ddc_pkg::PIN_P1], s2_q[ddc_pkg::PIN_P0],
                    func_q[5:0]};
            end else begin
                rb_word_d = (adr == ddc_pkg::ADR_B) ? dac_b_q : dac_a_q;
            end
        end else if (take && sel == ddc_pkg::SEL_FUNC) begin
            func_d = w[15:0];
        end else if (take && sel == ddc_pkg::SEL_DATA) begin
            if (adr == ddc_pkg::ADR_A || adr == ddc_pkg::ADR_ALL) begin
                in_a_d = w[15:0];
                dac_a_d = load_low ? w[15:0] : dac_a_q;
            end
            if (adr == ddc_pkg::ADR_B || adr == ddc_pkg::ADR_ALL) begin
                in_b_d = w[15:0];
                dac_b_d = load_low ? w[15:0] : dac_b_q;
            end
        end
        if (load_fall) begin
            dac_a_d = in_a_d;
            dac_b_d = in_b_d;
        end
        if (clear_fall) begin
            in_a_d = ddc_pkg::CLEAR_CODE;
            in_b_d = ddc_pkg::CLEAR_CODE;
            dac_a_d = ddc_pkg::CLEAR_CODE;
            dac_b_d = ddc_pkg::CLEAR_CODE;
        end
    end

    // Executor registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            in_a_q <= ddc_pkg::DAC_RST;
            in_b_q <= ddc_pkg::DAC_RST;
            dac_a_q <= ddc_pkg::DAC_RST;
            dac_b_q <= ddc_pkg::DAC_RST;
            func_q <= ddc_pkg::FUNC_RST;
            rb_word_q <= '0;
            rb_load_q <= 1'b0;
            rb_pend_q <= 1'b0;
        end else if (clk_en) begin
            in_a_q <= in_a_d;
            in_b_q <= in_b_d;
            dac_a_q <= dac_a_d;
            dac_b_q <= dac_b_d;
            func_q <= func_d;
            rb_word_q <= rb_word_d;
            rb_load_q <= rb_load_d;
            rb_pend_q <= rb_pend_d;
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic clamp_d;
    logic [15:0] code_a_d, code_b_d;

    // Core codes after coding select and clamp
    always_comb begin
        clamp_d = ~s2_q[ddc_pkg::PIN_CLAMP];
        code_a_d = ddc_pkg::ddc_to_core(dac_a_q, s2_q[ddc_pkg::PIN_CODE]);
        code_b_d = ddc_pkg::ddc_to_core(dac_b_q, s2_q[ddc_pkg::PIN_CODE]);
        if (clamp_d) begin
            code_a_d = ddc_pkg::MID_CODE;
            code_b_d = ddc_pkg::MID_CODE;
        end
    end

    // Output registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_a_code <= ddc_pkg::MID_CODE;
            dac_b_code <= ddc_pkg::MID_CODE;
            output_clamped <= 1'b1;
            monitor_reset_out <= 1'b0;
            port_pin_0_out <= 1'b0;
            port_pin_0_oe <= 1'b0;
            port_pin_1_out <= 1'b0;
            port_pin_1_oe <= 1'b0;
        end else if (clk_en) begin
            dac_a_code <= code_a_d;
            dac_b_code <= code_b_d;
            output_clamped <= clamp_d;
            monitor_reset_out <= 1'b1;
            port_pin_0_out <= func_q[ddc_pkg::FN_OUT0];
            port_pin_0_oe <= func_q[ddc_pkg::FN_DIR0];
            port_pin_1_out <= func_q[ddc_pkg::FN_OUT1];
            port_pin_1_oe <= func_q[ddc_pkg::FN_DIR1];
        end
    end

    assign serial_out = so_q;
    assign serial_out_en = so_en_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n || !clk_en);

    sequence s_frame_start;
        frame_fall && st_q == ddc_pkg::FR_IDLE;
    endsequence
    sequence s_counting;
        st_q == ddc_pkg::FR_SHIFT && cnt_q == '0;
    endsequence

    property p_shift_bit;
        (st_q == ddc_pkg::FR_SHIFT && sclk_fall && !frame_rise && !rb_load_q)
            |=> sh_q[0] == $past(s2_q[ddc_pkg::PIN_SDI]);
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("Serial bit not shifted");

    property p_sout_drive;
        (st_q == ddc_pkg::FR_SHIFT && sclk_rise && !frame_rise)
            |=> serial_out == $past(sh_q[ddc_pkg::FRAME_BITS-1]);
    endproperty
    a_sout_drive: assert property (p_sout_drive) else $error("Serial out not shift MSB");

    property p_clear;
        clear_fall |=> (dac_a_q == ddc_pkg::CLEAR_CODE && dac_b_q == ddc_pkg::CLEAR_CODE
            && in_a_q == ddc_pkg::CLEAR_CODE && in_b_q == ddc_pkg::CLEAR_CODE);
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not zero registers");

    property p_direct_load;
        (take && !w[ddc_pkg::RD_BIT] && sel == ddc_pkg::SEL_DATA && adr == ddc_pkg::ADR_A
            && load_low) |=> dac_a_q == $past(w[15:0]);
    endproperty
    a_direct_load: assert property (p_direct_load) else $error("Direct load missed");

    property p_sim_update;
        (load_fall && !clear_fall && !take) |=> (dac_a_q == $past(in_a_q)
            && dac_b_q == $past(in_b_q)) ##1 dac_a_code == ddc_pkg::MID_CODE || !output_clamped;
    endproperty
    a_sim_update: assert property (p_sim_update) else $error("Load strobe update wrong");

    property p_port_cfg;
        (take && !w[ddc_pkg::RD_BIT] && sel == ddc_pkg::SEL_FUNC)
            |=> ##1 (port_pin_0_oe == $past(w[ddc_pkg::FN_DIR0], 2)
            && port_pin_1_out == $past(w[ddc_pkg::FN_OUT1], 2));
    endproperty
    a_port_cfg: assert property (p_port_cfg) else $error("Port pin config not applied");

    property p_frame_restart;
        s_frame_start |=> s_counting;
    endproperty
    a_frame_restart: assert property (p_frame_restart) else $error("Bit count not restarted");

    property p_idle_quiet;
        (st_q == ddc_pkg::FR_IDLE && !frame_fall && !rb_load_q) |=> $stable(sh_q);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Shift while frame high");

    property p_coding;
        s2_q[ddc_pkg::PIN_CLAMP] |=> dac_a_code == ($past(s2_q[ddc_pkg::PIN_CODE])
            ? $past(dac_a_q) : ($past(dac_a_q) ^ ddc_pkg::MID_CODE));
    endproperty
    a_coding: assert property (p_coding) else $error("Output coding wrong");

    property p_clamp;
        (!s2_q[ddc_pkg::PIN_CLAMP] && !take && !clear_fall && !load_fall)
            |=> (dac_a_code == ddc_pkg::MID_CODE && dac_b_code == ddc_pkg::MID_CODE
            && $stable(dac_a_q) && $stable(dac_b_q));
    endproperty
    a_clamp: assert property (p_clamp) else $error("Clamp wrong or registers moved");
endmodule
`default_nettype wire

// ===== logic/ddc_pkg.sv
// Purpose: Shared constants, types and helpers of the dual DAC load control
// Assumes: 24-bit frames, MSB first; command layout is local to this block
// Notes:   Pin indices address the synchroniser vector in the top module
package ddc_pkg;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_CNT = 5'h18;
    localparam int DATA_W = 16;
    localparam int RD_BIT = 23;
    localparam int SEL_HI = 22;
    localparam int SEL_LO = 19;
    localparam int ADR_HI = 18;
    localparam int ADR_LO = 16;
    localparam logic [3:0] SEL_FUNC = 4'h0;
    localparam logic [3:0] SEL_DATA = 4'h2;
    localparam logic [2:0] ADR_A = 3'h0;
    localparam logic [2:0] ADR_B = 3'h1;
    localparam logic [2:0] ADR_ALL = 3'h4;

    // ****************************************************************
    // Function register fields and reset values
    // ****************************************************************
    localparam int FN_DAISY = 0;
    localparam int FN_DIR0 = 2;
    localparam int FN_DIR1 = 3;
    localparam int FN_OUT0 = 4;
    localparam int FN_OUT1 = 5;
    localparam logic [15:0] FUNC_RST = 16'h0000;
    localparam logic [15:0] DAC_RST = 16'h0000;
    localparam logic [15:0] CLEAR_CODE = 16'h0000;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [7:0] RB_PAD = 8'h00;

    // ****************************************************************
    // Synchroniser vector
    // ****************************************************************
    localparam int PIN_N = 9;
    localparam int PIN_SCLK = 0;
    localparam int PIN_FRM = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_CLEAR = 3;
    localparam int PIN_LOAD = 4;
    localparam int PIN_P0 = 5;
    localparam int PIN_P1 = 6;
    localparam int PIN_CLAMP = 7;
    localparam int PIN_CODE = 8;
    localparam logic [8:0] SYNC_RST = 9'h1fb;

    // ****************************************************************
    // Frame receiver states and helpers
    // ****************************************************************
    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_SHIFT = 2'b01,
        FR_PUSH = 2'b11
    } ddc_frame_st_t;

    // Register code to offset-binary code for the converter core
    function automatic logic [15:0] ddc_to_core(input logic [15:0] code, input logic offset_bin);
        ddc_to_core = offset_bin ? code : (code ^ MID_CODE);
    endfunction

endpackage

// ===== logic/ddc_word_if.sv
// Purpose: Valid/ready word channel between frame receiver, buffer and executor
// Assumes: A word moves on a cycle with valid and ready both high
// Notes:   src drives valid and data, snk drives ready
`timescale 1ns/1ns
`default_nettype none
interface ddc_word_if #(parameter int WIDTH = 24);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/ddc_word_buf.sv
// Purpose: Small FIFO of frame words with valid/ready on both sides
// Assumes: Same clock and clock enable on both sides
// Notes:   Full and empty are exact; a push into a full buffer is refused
`timescale 1ns/1ns
`default_nettype none
module ddc_word_buf #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    ddc_word_if.snk wr,
    ddc_word_if.src rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointer step with wrap at the last entry
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Handshake outputs
    assign wr.ready = (cnt_q != CW'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];
    assign push = wr.valid & wr.ready;
    assign pop = rd.valid & rd.ready;

    // Next storage, pointers and fill level
    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = wr.data;
            wp_d = next_ptr(wp_q);
        end
        if (pop) begin
            rp_d = next_ptr(rp_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (clk_en) begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ===== dv/ddc_host_model.sv
// Purpose: Host serial port model that sends frames to the load control
// Assumes: Serial clock idles high between frames, 125 ns period, MSB first
// Notes:   Data line shows the inverse of its last bit outside frames
`timescale 1ns/1ns
`default_nettype none
module ddc_host_model (
    input wire logic go,
    input wire logic [23:0] word,
    input wire logic [4:0] nbits,
    input wire logic serial_out,
    output logic busy,
    output logic [23:0] rx,
    output logic serial_clk,
    output logic frame_strobe_n,
    output logic serial_in
);
    // ****************************************************************
    // Frame sender
    // ****************************************************************
    // Idle levels from time zero
    initial begin
        busy = 1'b0;
        rx = 24'h000000;
        serial_clk = 1'b1;
        frame_strobe_n = 1'b1;
        serial_in = 1'b0;
    end

    // One frame per go pulse; bit set after a rise, taken at the fall
    always @(posedge go) begin
        busy = 1'b1;
        frame_strobe_n = 1'b0;
        #63;
        for (int i = 0; i < int'(nbits); i++) begin
            serial_in = word[23 - i];
            #62;
            serial_clk = 1'b0;
            rx = {rx[22:0], serial_out};
            #63;
            serial_clk = 1'b1;
        end
        #63;
        frame_strobe_n = 1'b1;
        serial_in = ~serial_in;
        #125; // Frame high time above 90 ns
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// ===== dv/ddc_dac_load_ctrl_tb_top.sv
// Purpose: Self-checking bench of the dual DAC load control
// Assumes: clk_en held high; host model drives the link
// Notes:   Ordinary writes come from a row table, the rest is hand-written
`timescale 1ns/1ns
`default_nettype none
module ddc_dac_load_ctrl_tb_top;
    typedef struct packed {logic [23:0] word; logic coding; logic [15:0] ra; logic [15:0] rb;} ddc_row_t;
    logic core_clk, arst_n, serial_clk, frame_strobe_n, serial_in, serial_out, serial_out_en;
    logic clear_n, load_strobe_n, p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, pin1_ext;
    logic output_clamp_in, coding_select, monitor_reset_out, output_clamped;
    logic [15:0] dac_a_code, dac_b_code;
    logic h_go, h_busy;
    logic [4:0] h_n;
    logic [23:0] h_word, h_rx;
    int errors, n_compared, cycles;
    ddc_row_t rows [4] = '{'{24'h101234, 1'b1, 16'h1234, 16'h0000},
        '{24'h11abcd, 1'b1, 16'h1234, 16'habcd}, '{24'h145555, 1'b1, 16'h5555, 16'h5555},
        '{24'h100001, 1'b0, 16'h0001, 16'h5555}};

    // ****************************************************************
    // Design, host and pins
    // ****************************************************************
    // Pin 0 has a pull-up when not driven, pin 1 follows the bench level
    assign p0_in = p0_oe ? p0_out : 1'b1;
    assign p1_in = p1_oe ? p1_out : pin1_ext;
    ddc_dac_load_ctrl u_ddc_dac_load_ctrl (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
        .serial_clk(serial_clk), .frame_strobe_n(frame_strobe_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en), .clear_n(clear_n),
        .load_strobe_n(load_strobe_n), .port_pin_0_in(p0_in), .port_pin_0_out(p0_out),
        .port_pin_0_oe(p0_oe), .port_pin_1_in(p1_in), .port_pin_1_out(p1_out),
        .port_pin_1_oe(p1_oe), .output_clamp_in(output_clamp_in), .coding_select(coding_select),
        .monitor_reset_out(monitor_reset_out), .output_clamped(output_clamped),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
    ddc_host_model u_ddc_host_model (.go(h_go), .word(h_word), .nbits(h_n),
        .serial_out(serial_out), .busy(h_busy), .rx(h_rx), .serial_clk(serial_clk),
        .frame_strobe_n(frame_strobe_n), .serial_in(serial_in));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Expected core code of a register value
    function automatic logic [23:0] code_of(input logic [15:0] r, input logic cod);
        code_of = {8'h00, cod ? r : (r ^ 16'h8000)};
    endfunction

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Sends one frame and lets the write settle
    task automatic send(input logic [23:0] w, input logic [4:0] n);
        int k;
        k = 0;
        h_word <= w;
        h_n <= n;
        h_go <= 1'b1;
        @(posedge core_clk);
        h_go <= 1'b0;
        while (h_busy !== 1'b0 && k < 1000) begin
            @(posedge core_clk);
            k++;
        end
        if (k == 1000) errors++;
        repeat (20) @(posedge core_clk);
    endtask

    task automatic codes(input logic [15:0] a, input logic [15:0] b);
        chk("dac_a_code", code_of(a, coding_select), {8'h00, dac_a_code});
        chk("dac_b_code", code_of(b, coding_select), {8'h00, dac_b_code});
    endtask

    task automatic results;
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, timeout and sequence
    // ****************************************************************
    // Core clock of 8 ns
    always #4 core_clk = ~core_clk;

    // Cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    // Main sequence
    initial begin
        core_clk = 1'b0;
        arst_n = 1'b0;
        clear_n = 1'b1;
        load_strobe_n = 1'b0;
        output_clamp_in = 1'b1;
        coding_select = 1'b1;
        pin1_ext = 1'b0;
        h_go = 1'b0;
        h_word = 24'h000000;
        h_n = 5'h18;
        repeat (10) @(posedge core_clk);
        chk("reset code", 24'h008000, {8'h00, dac_a_code});
        chk("output_clamped", 24'h000001, {23'h0, output_clamped});
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("monitor_reset_out", 24'h000001, {23'h0, monitor_reset_out});
        foreach (rows[i]) begin
            coding_select <= rows[i].coding;
            send(rows[i].word, 5'h18);
            codes(rows[i].ra, rows[i].rb);
        end
        coding_select <= 1'b1;
        load_strobe_n <= 1'b1;
        send(24'h107777, 5'h18);
        send(24'h112222, 5'h18);
        codes(16'h0001, 16'h5555);
        load_strobe_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        codes(16'h7777, 16'h2222);
        send(24'h10ffff, 5'h14);
        codes(16'h7777, 16'h2222);
        send(24'h100f0f, 5'h18);
        codes(16'h0f0f, 16'h2222);
        output_clamp_in <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("clamped a", 24'h008000, {8'h00, dac_a_code});
        chk("clamped b", 24'h008000, {8'h00, dac_b_code});
        chk("output_clamped", 24'h000001, {23'h0, output_clamped});
        output_clamp_in <= 1'b1;
        repeat (10) @(posedge core_clk);
        codes(16'h0f0f, 16'h2222);
        send(24'ha00000, 5'h18);
        chk("serial_out_en", 24'h000001, {23'h0, serial_out_en});
        send(24'ha00000, 5'h18);
        chk("readback", 24'h000f0f, h_rx);
        send(24'h000034, 5'h18);
        chk("pin drive", 24'h00000d, {20'h0, p0_oe, p0_out, p1_oe, p1_out});
        send(24'h800000, 5'h18);
        send(24'h800000, 5'h18);
        chk("pin levels", 24'h000001, {22'h0, h_rx[7:6]});
        clear_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        codes(16'h0000, 16'h0000);
        clear_n <= 1'b1;
        results();
    end
endmodule
`default_nettype wire
